/* hw/pmicpe_consts.vh */
`ifndef PMICPE_CONSTS_VH
`define PMICPE_CONSTS_VH
// register offsets
`define PMICPE_OFS_BLOCK_ENABLE 8'h00
`define PMICPE_OFS_LOCK_REV 8'h01
`define PMICPE_OFS_AON_SETTING 8'h02
// block_enable fields
`define PMICPE_BIT_CONV_EN 0
`define PMICPE_BIT_REG_EN 1
`define PMICPE_BIT_CONV_AMP 2
`define PMICPE_BIT_MAX_AUX_ONE 3
`define PMICPE_BIT_REG_RADIO 4
`define PMICPE_BIT_REG_AUX_TWO 5
`define PMICPE_BIT_REG_MICRO 6
`define PMICPE_BIT_SINGLE_WIRE 7
// lock register fields
`define PMICPE_BIT_UNLOCK 7
`define PMICPE_REV_MSB 3
// always-on setting fields
`define PMICPE_AON_LVL_MSB 3
`define PMICPE_AON_MODE_LSB 6
// reset values
`define PMICPE_RST_BLOCK_ENABLE 8'h00
`define PMICPE_RST_AON_SETTING 8'h04
`define PMICPE_RST_UNLOCK 1'h0
// revision value is arbitrary
`define PMICPE_REVISION 4'h3
// read value of unmapped or locked register
`define PMICPE_RD_EMPTY 8'h00
// always-on interpretation codes
`define PMICPE_AON_DROP_FIRST 4'h0
`define PMICPE_AON_DROP_LAST 4'h7
`define PMICPE_AON_VBAT_LAST 4'hd
`define PMICPE_AON_UNSUPPORTED 4'he
`define PMICPE_AON_DISCONNECT 4'hf
`endif

/* hw/pmicpe_regs.v */
// Overview of operation
// - converter runs on register bit OR pin
// - bit 7 closes battery-to-single-wire switch
// - bit 6 closes regulator-to-micro switch
// - bit 5 closes regulator-to-aux-two switch
// - bit 4 closes regulator-to-radio switch
// - bit 3 closes max-rail-to-aux-one switch
// - bit 2 closes converter-to-amplifier switch
// - lock bit 7 must be set first
// - factory option picks drop or absolute level
// - drop codes, vbat codes, unsupported, disconnect
// - enable bits: one means on
// - unmapped address reads 00h
`include "pmicpe_consts.vh"
module pmicpe_regs (
    // clock and reset
    input wire clk,
    input wire rst,
    // register access from the serial interface
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] rdata_ff,
    // pins and factory option
    input wire converter_en_pin,
    input wire drop_mode_opt,
    // power controls
    output reg converter_en_ff,
    output reg regulator_en_ff,
    output reg converter_to_amplifier_switch_en_ff,
    output reg max_rail_to_aux_one_switch_en_ff,
    output reg regulator_to_radio_switch_en_ff,
    output reg regulator_to_aux_two_switch_en_ff,
    output reg regulator_to_micro_switch_en_ff,
    output reg single_wire_switch_en_ff,
    // always-on supply control
    output reg [3:0] always_on_level_ff,
    output reg aon_drop_mode_ff,
    output reg aon_track_vbat_ff,
    output reg aon_disconnect_ff,
    output reg aon_code_invalid_ff
);
    reg [7:0] block_enable_ff;
    reg [7:0] aon_setting_ff;
    reg unlock_ff;
    reg [7:0] nxt_block_enable;
    reg [7:0] nxt_aon_setting;
    reg nxt_unlock;
    reg [7:0] nxt_rdata;
    reg nxt_track_vbat;
    reg nxt_disconnect;
    reg nxt_code_invalid;
    wire [1:0] async_in;
    wire [1:0] async_sync;
    wire pin_sync;
    wire opt_sync;
    wire sel_block_enable;
    wire sel_lock_rev;
    wire sel_aon_setting;
    wire nxt_converter_en;
    wire [3:0] lvl;

    function is_reg;
        input [7:0] a;
        input [7:0] ofs;
        begin
            is_reg = (a == ofs);
        end
    endfunction

    // inclusive code window test
    function in_code_range;
        input [3:0] code;
        input [3:0] lo;
        input [3:0] hi;
        begin
            in_code_range = (code >= lo) && (code <= hi);
        end
    endfunction

    assign async_in = {drop_mode_opt, converter_en_pin};

    // pins are asynchronous to clk; only the second flop is read
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            reg meta_ff;
            reg sync_ff;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end else begin
                    meta_ff <= async_in[gi];
                    sync_ff <= meta_ff;
                end
            end
            assign async_sync[gi] = sync_ff;
        end
    endgenerate

    assign pin_sync = async_sync[0];
    assign opt_sync = async_sync[1];

    assign sel_block_enable = is_reg(addr, `PMICPE_OFS_BLOCK_ENABLE);
    assign sel_lock_rev = is_reg(addr, `PMICPE_OFS_LOCK_REV);
    assign sel_aon_setting = is_reg(addr, `PMICPE_OFS_AON_SETTING);

    // lock register stays reachable so a locked part can be reopened
    always @* begin
        nxt_unlock = unlock_ff;
        nxt_block_enable = block_enable_ff;
        nxt_aon_setting = aon_setting_ff;
        if (wr_stb && sel_lock_rev) begin
            // revision bits are not stored, so writes never reach them
            nxt_unlock = wdata[`PMICPE_BIT_UNLOCK];
        end
        // enable bits stored as written: 1 turns the block on
        if (wr_stb && unlock_ff && sel_block_enable) begin
            nxt_block_enable = wdata;
        end
        if (wr_stb && unlock_ff && sel_aon_setting) begin
            nxt_aon_setting = wdata;
        end
    end

    // stored registers; the lock resets closed
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            unlock_ff <= `PMICPE_RST_UNLOCK;
        end else begin
            unlock_ff <= nxt_unlock;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            block_enable_ff <= `PMICPE_RST_BLOCK_ENABLE;
        end else begin
            block_enable_ff <= nxt_block_enable;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            aon_setting_ff <= `PMICPE_RST_AON_SETTING;
        end else begin
            aon_setting_ff <= nxt_aon_setting;
        end
    end

    // locked registers read as empty, same as unmapped ones
    always @* begin
        nxt_rdata = `PMICPE_RD_EMPTY;
        if (sel_lock_rev) begin
            nxt_rdata = {unlock_ff, 3'h0, `PMICPE_REVISION};
        end else if (unlock_ff && sel_block_enable) begin
            nxt_rdata = block_enable_ff;
        end else if (unlock_ff && sel_aon_setting) begin
            nxt_rdata = aon_setting_ff;
        end
    end

    // read data holds until the next read strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= `PMICPE_RD_EMPTY;
        end else if (rd_stb) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign lvl = aon_setting_ff[`PMICPE_AON_LVL_MSB:0];
    // pin is or-ed in after the sync, never raw
    assign nxt_converter_en = block_enable_ff[`PMICPE_BIT_CONV_EN] | pin_sync;

    // absolute option uses every code as a level, so no flag rises there
    always @* begin
        nxt_track_vbat = 1'b0;
        nxt_disconnect = 1'b0;
        nxt_code_invalid = 1'b0;
        if (opt_sync) begin
            nxt_track_vbat = in_code_range(lvl, `PMICPE_AON_DROP_LAST + 4'h1, `PMICPE_AON_VBAT_LAST);
            nxt_disconnect = (lvl == `PMICPE_AON_DISCONNECT);
            nxt_code_invalid = (lvl == `PMICPE_AON_UNSUPPORTED);
        end
    end

    // one flop after the stored bits, so every output is glitch free
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            converter_en_ff <= 1'b0;
            regulator_en_ff <= 1'b0;
            converter_to_amplifier_switch_en_ff <= 1'b0;
            max_rail_to_aux_one_switch_en_ff <= 1'b0;
            regulator_to_radio_switch_en_ff <= 1'b0;
            regulator_to_aux_two_switch_en_ff <= 1'b0;
            regulator_to_micro_switch_en_ff <= 1'b0;
            single_wire_switch_en_ff <= 1'b0;
            always_on_level_ff <= 4'h0;
            aon_drop_mode_ff <= 1'b0;
            aon_track_vbat_ff <= 1'b0;
            aon_disconnect_ff <= 1'b0;
            aon_code_invalid_ff <= 1'b0;
        end else begin
            converter_en_ff <= nxt_converter_en;
            regulator_en_ff <= block_enable_ff[`PMICPE_BIT_REG_EN];
            converter_to_amplifier_switch_en_ff <= block_enable_ff[`PMICPE_BIT_CONV_AMP];
            max_rail_to_aux_one_switch_en_ff <= block_enable_ff[`PMICPE_BIT_MAX_AUX_ONE];
            regulator_to_radio_switch_en_ff <= block_enable_ff[`PMICPE_BIT_REG_RADIO];
            regulator_to_aux_two_switch_en_ff <= block_enable_ff[`PMICPE_BIT_REG_AUX_TWO];
            regulator_to_micro_switch_en_ff <= block_enable_ff[`PMICPE_BIT_REG_MICRO];
            single_wire_switch_en_ff <= block_enable_ff[`PMICPE_BIT_SINGLE_WIRE];
            always_on_level_ff <= lvl;
            aon_drop_mode_ff <= opt_sync;
            aon_track_vbat_ff <= nxt_track_vbat;
            aon_disconnect_ff <= nxt_disconnect;
            aon_code_invalid_ff <= nxt_code_invalid;
        end
    end
endmodule

/* tb/pmic_power_enable_regs_bench.sv */
module pmic_power_enable_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, pin = 0, opt = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, d;
    wire [7:0] rdata, en;
    wire [3:0] lvl;
    wire drop, vb, dis, inv;
    int err_count = 0, checks_done = 0;
    always #25 clk = ~clk;
    pmicpe_regs dut (.clk(clk), .rst(rst), .wr_stb(wr_stb), .rd_stb(rd_stb), .addr(addr), .wdata(wdata),
        .rdata_ff(rdata), .converter_en_pin(pin), .drop_mode_opt(opt), .converter_en_ff(en[0]),
        .regulator_en_ff(en[1]), .converter_to_amplifier_switch_en_ff(en[2]), .max_rail_to_aux_one_switch_en_ff(en[3]),
        .regulator_to_radio_switch_en_ff(en[4]), .regulator_to_aux_two_switch_en_ff(en[5]),
        .regulator_to_micro_switch_en_ff(en[6]), .single_wire_switch_en_ff(en[7]), .always_on_level_ff(lvl),
        .aon_drop_mode_ff(drop), .aon_track_vbat_ff(vb), .aon_disconnect_ff(dis), .aon_code_invalid_ff(inv));
    function automatic logic [7:0] aon_exp(input logic [3:0] c, input logic m);
        return m ? {5'h0, c inside {[4'h8:4'hd]}, c == 4'hf, c == 4'he} : 8'h00;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // one strobe, then idle long enough for outputs to settle
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        wr_stb = w;
        rd_stb = !w;
        addr = a;
        wdata = v;
        @(negedge clk);
        wr_stb = 0;
        rd_stb = 0;
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        acc(0, a, 8'h00);
        chk(rdata, exp);
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d, checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(18219));
        repeat (6) @(negedge clk);
        rst = 0;
        rd(8'h01, 8'h03);
        acc(1, 8'h00, 8'hff);
        chk(en, 8'h00);
        acc(1, 8'h02, 8'h0a);
        chk({4'h0, lvl}, 8'h04);
        rd(8'h00, 8'h00);
        acc(1, 8'h01, 8'hff);
        rd(8'h01, 8'h83);
        rd(8'h02, 8'h04);
        rd(8'h00, 8'h00);
        for (int i = 0; i < 20; i++) begin
            d = (i < 8) ? 8'h01 << i : 8'($urandom);
            acc(1, 8'h00, d);
            chk(en, d);
            rd(8'h00, d);
            rd(8'h03 + 8'($urandom_range(252)), 8'h00);
        end
        acc(1, 8'h00, 8'h00);
        pin = 1;
        repeat (5) @(negedge clk);
        chk(en, 8'h01);
        pin = 0;
        for (int m = 0; m < 2; m++) for (int c = 0; c < 16; c++) begin
            opt = m[0];
            acc(1, 8'h02, 8'(c));
            repeat (3) @(negedge clk);
            chk({4'h0, lvl}, 8'(c));
            chk({7'h0, drop}, {7'h0, opt});
            chk({5'h0, vb, dis, inv}, aon_exp(c[3:0], opt));
        end
        acc(1, 8'h01, 8'h00);
        rd(8'h02, 8'h00);
        tally_and_finish;
    end
endmodule

/* tb/pmicpe_regs_properties.sv */
module pmicpe_regs_properties (
    // access
    input wire clk,
    input wire rst,
    input wire rd_stb,
    input wire [7:0] addr,
    input wire [7:0] rdata_ff,
    // pins
    input wire converter_en_pin,
    input wire drop_mode_opt,
    // controls
    input wire converter_en_ff,
    input wire [3:0] always_on_level_ff,
    input wire aon_drop_mode_ff,
    input wire aon_track_vbat_ff,
    input wire aon_disconnect_ff,
    input wire aon_code_invalid_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    unmapped_read_a: assert property (rd_stb && addr > 8'h02 |=> rdata_ff == 8'h00)
        else $error("unmapped read");
    revision_field_a: assert property (rd_stb && addr == 8'h01 |=> rdata_ff[6:0] == 7'h03)
        else $error("revision field");
    pin_enable_a: assert property (converter_en_pin [*5] |-> converter_en_ff)
        else $error("pin enable");
    option_follow_a: assert property (drop_mode_opt [*5] |-> aon_drop_mode_ff)
        else $error("option follow");
    absolute_flags_a: assert property (!aon_drop_mode_ff
        |-> !(aon_track_vbat_ff | aon_disconnect_ff | aon_code_invalid_ff))
        else $error("absolute flags");
    disconnect_code_a: assert property (aon_disconnect_ff && $stable(always_on_level_ff) |-> &always_on_level_ff)
        else $error("disconnect code");
    vbat_code_a: assert property (aon_track_vbat_ff |-> always_on_level_ff inside {[4'h8:4'hd]})
        else $error("vbat code");
    unsupported_code_a: assert property (aon_code_invalid_ff |-> aon_drop_mode_ff)
        else $error("unsupported code");
endmodule
// checker watches only the top ports
bind pmicpe_regs pmicpe_regs_properties chk_i (
    .clk(clk),
    .rst(rst),
    .rd_stb(rd_stb),
    .addr(addr),
    .rdata_ff(rdata_ff),
    .converter_en_pin(converter_en_pin),
    .drop_mode_opt(drop_mode_opt),
    .converter_en_ff(converter_en_ff),
    .always_on_level_ff(always_on_level_ff),
    .aon_drop_mode_ff(aon_drop_mode_ff),
    .aon_track_vbat_ff(aon_track_vbat_ff),
    .aon_disconnect_ff(aon_disconnect_ff),
    .aon_code_invalid_ff(aon_code_invalid_ff)
);
